// File: logic/pdp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes sys_clk, synchronous active-low reset and a freezing clock enable.
module pdp_pin_sync (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    input  wire logic   clk_en,
    // Pins
    pdp_sync_if.syncer  pins
);
    // ==========================================
    // Stages
    localparam int W = $bits(pins.raw);
    logic [W-1:0] st1_reg, st2_reg, st3_reg, clean_reg;
    logic [W-1:0] st1_next, st2_next, st3_next, clean_next;

    // A change counts only once the second and third stages agree
    always_comb begin
        st1_next   = pins.raw;
        st2_next   = st1_reg;
        st3_next   = st2_reg;
        clean_next = clean_reg;
        for (int i = 0; i < W; i++) begin
            if (st2_reg[i] == st3_reg[i]) begin
                clean_next[i] = st3_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st1_reg   <= '0;
            st2_reg   <= '0;
            st3_reg   <= '0;
            clean_reg <= '0;
        end else if (clk_en) begin
            st1_reg   <= st1_next;
            st2_reg   <= st2_next;
            st3_reg   <= st3_next;
            clean_reg <= clean_next;
        end
    end

    assign pins.clean = clean_reg;
endmodule : pdp_pin_sync

// File: logic/pdp_pkg.sv
// Package for the port direction, pull-up and pin-mode block.
// Assumes registers are reached over Avalon-MM, one register per aligned word.
package pdp_pkg;
    // ==========================================
    // Register indices (byte address = 4 * index)
    localparam logic [15:0] IDX_SERIAL_CTRL = 16'hFF91;
    localparam logic [15:0] IDX_DISPLAY_CTL = 16'hFFC0;
    localparam logic [15:0] IDX_P4_MODE_TWO = 16'hFFC9;
    localparam logic [15:0] IDX_P3_MODE     = 16'hFFCA;
    localparam logic [15:0] IDX_P3_DATA     = 16'hFFD6;
    localparam logic [15:0] IDX_P4_DATA     = 16'hFFD7;
    localparam logic [15:0] IDX_P8_DATA     = 16'hFFDB;
    localparam logic [15:0] IDX_P9_DATA     = 16'hFFDC;
    localparam logic [15:0] IDX_P3_PULLUP   = 16'hFFE1;
    localparam logic [15:0] IDX_P3_DIR      = 16'hFFE6;
    localparam logic [15:0] IDX_P4_DIR      = 16'hFFE7;
    localparam logic [15:0] IDX_P8_DIR      = 16'hFFEB;
    localparam logic [15:0] IDX_P9_MODE     = 16'hFFEC;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_P4_DATA = 8'hF8;
    localparam logic [7:0] RST_P4_DIR  = 8'hF8;
    localparam logic [7:0] RST_P9_DATA = 8'hFF;
    // ==========================================
    // Storable bits and bits that always read as one
    localparam logic [7:0] MASK_P3_PINS  = 8'hFE;
    localparam logic [7:0] MASK_P3_MODE  = 8'hC6;
    localparam logic [7:0] MASK_MODE_TWO = 8'h21;
    localparam logic [7:0] ONES_MODE_TWO = 8'hD8;
    localparam logic [7:0] MASK_P9_MODE  = 8'h0B;
    localparam logic [7:0] ONES_P9_MODE  = 8'hF0;
    localparam logic [7:0] MASK_SERIAL   = 8'h2C;
    localparam logic [7:0] ONES_SERIAL   = 8'hC0;
    localparam logic [7:0] MASK_P8       = 8'h01;
    localparam logic [7:0] READ_P3_DIR   = 8'hFE;
    localparam logic [7:0] READ_P4_DIR   = 8'hFF;
    localparam logic [7:0] READ_P8_DIR   = 8'h01;
    // ==========================================
    // Field positions
    localparam int BIT_PMOS_OFF  = 5;
    localparam int BIT_EXT_INTERRUPT0_PIN_SELECT_SEL  = 0;
    localparam int BIT_EXT_INTERRUPT0_PIN_SELECT_PIN  = 3;
    localparam int BIT_PMOS_PIN  = 5;
    localparam int BIT_PWM_OFF   = 3;
    localparam int BIT_SPC_SEL   = 5;
    localparam int BIT_TX_INV    = 3;
    localparam int BIT_RX_INV    = 2;
    localparam int SYNC_W        = 18;
endpackage : pdp_pkg

// File: logic/pdp_port_regs.sv
// Port direction, pull-up, pin-mode and serial inversion registers.
// Assumes an Avalon-MM master with waitrequest and pins asynchronous to sys_clk.
//
// Summary of operation
// - Direction bit one drives pin, zero inputs
// - Direction and data act only in general mode; port 9 data drives p9_out in every mode
// - First port direction reads ones in 7..1
// - Input pin pull-up follows pull-up bit
// - Single pin read: latch if output, else pin
// - Single pin active only for its segment code
// - Single pin direction reads one in bit 0
// - First port mode selects functions, reserved ignored
// - Mode two selects interrupt pin and PMOS off
// - Mode two bits 7,6,4,3 read one
// - Third port mode selects PWM pins
// - Serial control inverts receive and transmit data
// - First port read: latch if output, else pin
//
// Implementation choice: the Avalon-MM slave port.
module pdp_port_regs #(
    parameter logic [3:0] P8_GPIO_SEGMENT = 4'h0
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire logic [17:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Port 3 pins
    input  wire logic [7:0]  p3_in,
    output logic      [7:0]  p3_out,
    output logic      [7:0]  p3_oe,
    output logic      [7:0]  p3_pullup_en,
    output logic      [7:0]  p3_alt_sel,
    output logic             p35_pmos_off,
    // Port 4 pins
    input  wire logic [7:0]  p4_in,
    output logic      [7:0]  p4_out,
    output logic      [7:0]  p4_oe,
    output logic             p4_ext_interrupt0_pin_select_sel,
    // Port 8 pin
    input  wire logic        p8_in,
    output logic             p8_out,
    output logic             p8_oe,
    // Port 9 pins
    output logic      [7:0]  p9_out,
    output logic      [1:0]  p9_pwm_sel,
    output logic             p9_pwm_drive_off,
    // Serial pins
    input  wire logic        serial_receive_pin,
    output logic             serial_transmit_pin,
    input  wire logic        sci_tx_data,
    output logic             sci_rx_data,
    output logic             serial_pin_function_select
);
    // ==========================================
    // Pin synchroniser
    pdp_sync_if #(.W(pdp_pkg::SYNC_W)) sync_bus ();
    assign sync_bus.raw = {serial_receive_pin, p8_in, p4_in, p3_in};
    pdp_pin_sync u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .pins    (sync_bus)
    );
    logic [7:0] p3_pin, p4_pin;
    logic       p8_pin, rx_pin;
    assign {rx_pin, p8_pin, p4_pin, p3_pin} = sync_bus.clean;

    function automatic logic [7:0] pdp_mix(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
        pdp_mix = (dir & latch) | (~dir & pin);
    endfunction : pdp_mix

    // ==========================================
    // Bus handshake: one wait cycle, then the answer
    logic        ack_reg, ack_next;
    logic [7:0]  rdata_reg, rdata_next, rd_val;
    logic [15:0] idx;
    logic        req, wr_commit;
    assign idx       = avs_address[17:2];
    assign req       = avs_read | avs_write;
    assign wr_commit = clk_en & avs_write & ack_reg & avs_byteenable[0];
    assign avs_waitrequest = req & ~(ack_reg & clk_en);
    assign avs_readdata    = {24'h000000, rdata_reg};

    always_comb begin
        ack_next   = req & ~ack_reg;
        rdata_next = (avs_read & ~ack_reg) ? rd_val : rdata_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================
    // Register storage
    logic [7:0] p3_dir_reg, p3_data_reg, p3_pull_reg, p3_mode_reg;
    logic [7:0] p3_dir_next, p3_data_next, p3_pull_next, p3_mode_next;
    logic [7:0] p4_dir_reg, p4_data_reg, mode_two_reg, p9_data_reg, p9_mode_reg;
    logic [7:0] p4_dir_next, p4_data_next, mode_two_next, p9_data_next, p9_mode_next;
    logic [7:0] p8_dir_reg, p8_data_reg, disp_reg, serial_reg;
    logic [7:0] p8_dir_next, p8_data_next, disp_next, serial_next;
    logic [7:0] wd;
    assign wd = avs_writedata[7:0];

    // Reserved bits are masked off, so a stray one never reaches the pins
    always_comb begin
        p3_dir_next   = p3_dir_reg;
        p3_data_next  = p3_data_reg;
        p3_pull_next  = p3_pull_reg;
        p3_mode_next  = p3_mode_reg;
        p4_dir_next   = p4_dir_reg;
        p4_data_next  = p4_data_reg;
        mode_two_next = mode_two_reg;
        p9_data_next  = p9_data_reg;
        p9_mode_next  = p9_mode_reg;
        p8_dir_next   = p8_dir_reg;
        p8_data_next  = p8_data_reg;
        disp_next     = disp_reg;
        serial_next   = serial_reg;
        if (wr_commit) begin
            case (idx)
                pdp_pkg::IDX_P3_DIR:      p3_dir_next   = wd & pdp_pkg::MASK_P3_PINS;
                pdp_pkg::IDX_P3_DATA:     p3_data_next  = wd & pdp_pkg::MASK_P3_PINS;
                pdp_pkg::IDX_P3_PULLUP:   p3_pull_next  = wd & pdp_pkg::MASK_P3_PINS;
                pdp_pkg::IDX_P3_MODE:     p3_mode_next  = wd & pdp_pkg::MASK_P3_MODE;
                pdp_pkg::IDX_P4_DIR:      p4_dir_next   = wd;
                pdp_pkg::IDX_P4_DATA:     p4_data_next  = wd;
                pdp_pkg::IDX_P4_MODE_TWO: mode_two_next = wd & pdp_pkg::MASK_MODE_TWO;
                pdp_pkg::IDX_P9_DATA:     p9_data_next  = wd;
                pdp_pkg::IDX_P9_MODE:     p9_mode_next  = wd & pdp_pkg::MASK_P9_MODE;
                pdp_pkg::IDX_P8_DIR:      p8_dir_next   = wd & pdp_pkg::MASK_P8;
                pdp_pkg::IDX_P8_DATA:     p8_data_next  = wd & pdp_pkg::MASK_P8;
                pdp_pkg::IDX_DISPLAY_CTL: disp_next     = wd;
                pdp_pkg::IDX_SERIAL_CTRL: serial_next   = wd & pdp_pkg::MASK_SERIAL;
                default:                  p3_dir_next   = p3_dir_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p3_dir_reg   <= pdp_pkg::RST_ZERO;
            p3_data_reg  <= pdp_pkg::RST_ZERO;
            p3_pull_reg  <= pdp_pkg::RST_ZERO;
            p3_mode_reg  <= pdp_pkg::RST_ZERO;
            p4_dir_reg   <= pdp_pkg::RST_P4_DIR;
            p4_data_reg  <= pdp_pkg::RST_P4_DATA;
            mode_two_reg <= pdp_pkg::RST_ZERO;
            p9_data_reg  <= pdp_pkg::RST_P9_DATA;
            p9_mode_reg  <= pdp_pkg::RST_ZERO;
            p8_dir_reg   <= pdp_pkg::RST_ZERO;
            p8_data_reg  <= pdp_pkg::RST_ZERO;
            disp_reg     <= pdp_pkg::RST_ZERO;
            serial_reg   <= pdp_pkg::RST_ZERO;
        end else if (clk_en) begin
            p3_dir_reg   <= p3_dir_next;
            p3_data_reg  <= p3_data_next;
            p3_pull_reg  <= p3_pull_next;
            p3_mode_reg  <= p3_mode_next;
            p4_dir_reg   <= p4_dir_next;
            p4_data_reg  <= p4_data_next;
            mode_two_reg <= mode_two_next;
            p9_data_reg  <= p9_data_next;
            p9_mode_reg  <= p9_mode_next;
            p8_dir_reg   <= p8_dir_next;
            p8_data_reg  <= p8_data_next;
            disp_reg     <= disp_next;
            serial_reg   <= serial_next;
        end
    end

    // ==========================================
    // Read decode; write-only registers return fixed patterns
    always_comb begin
        case (idx)
            pdp_pkg::IDX_P3_DIR:      rd_val = pdp_pkg::READ_P3_DIR;
            pdp_pkg::IDX_P3_DATA:     rd_val = pdp_mix(p3_dir_reg, p3_data_reg, p3_pin)
                                               & pdp_pkg::MASK_P3_PINS;
            pdp_pkg::IDX_P3_PULLUP:   rd_val = p3_pull_reg;
            pdp_pkg::IDX_P3_MODE:     rd_val = p3_mode_reg;
            pdp_pkg::IDX_P4_DIR:      rd_val = pdp_pkg::READ_P4_DIR;
            pdp_pkg::IDX_P4_DATA:     rd_val = pdp_mix(p4_dir_reg, p4_data_reg, p4_pin);
            pdp_pkg::IDX_P4_MODE_TWO: rd_val = mode_two_reg | pdp_pkg::ONES_MODE_TWO;
            pdp_pkg::IDX_P9_DATA:     rd_val = p9_data_reg;
            pdp_pkg::IDX_P9_MODE:     rd_val = p9_mode_reg | pdp_pkg::ONES_P9_MODE;
            pdp_pkg::IDX_P8_DIR:      rd_val = pdp_pkg::READ_P8_DIR;
            pdp_pkg::IDX_P8_DATA:     rd_val = pdp_mix(p8_dir_reg, p8_data_reg,
                                                       {7'h00, p8_pin});
            pdp_pkg::IDX_DISPLAY_CTL: rd_val = disp_reg;
            pdp_pkg::IDX_SERIAL_CTRL: rd_val = serial_reg | pdp_pkg::ONES_SERIAL;
            default:                  rd_val = 8'h00;
        endcase
    end

    // ==========================================
    // Pin control
    logic [7:0] p4_gpio;
    logic       p8_gpio;
    assign p3_alt_sel   = p3_mode_reg;
    assign p3_oe        = p3_dir_reg & ~p3_mode_reg;
    assign p3_out       = p3_data_reg & ~p3_mode_reg;
    assign p3_pullup_en = p3_pull_reg & ~p3_dir_reg;
    assign p35_pmos_off = mode_two_reg[pdp_pkg::BIT_PMOS_OFF];
    assign p4_ext_interrupt0_pin_select_sel  = mode_two_reg[pdp_pkg::BIT_EXT_INTERRUPT0_PIN_SELECT_SEL];
    // Interrupt input takes the pin away from the port
    assign p4_gpio      = ~({7'h00, p4_ext_interrupt0_pin_select_sel} << pdp_pkg::BIT_EXT_INTERRUPT0_PIN_SELECT_PIN);
    assign p4_oe        = p4_dir_reg & p4_gpio;
    assign p4_out       = p4_data_reg & p4_gpio;
    assign p8_gpio      = (disp_reg[3:0] == P8_GPIO_SEGMENT);
    assign p8_oe        = p8_dir_reg[0] & p8_gpio;
    assign p8_out       = p8_data_reg[0] & p8_gpio;
    assign p9_out       = p9_data_reg;
    assign p9_pwm_sel   = p9_mode_reg[1:0];
    assign p9_pwm_drive_off          = p9_mode_reg[pdp_pkg::BIT_PWM_OFF];
    assign serial_pin_function_select = serial_reg[pdp_pkg::BIT_SPC_SEL];

    // ==========================================
    // Serial inversion, registered so the pin never glitches on a write
    logic tx_reg, tx_next, rx_reg, rx_next;
    always_comb begin
        tx_next = sci_tx_data ^ serial_reg[pdp_pkg::BIT_TX_INV];
        rx_next = rx_pin ^ serial_reg[pdp_pkg::BIT_RX_INV];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_reg <= 1'b0;
            rx_reg <= 1'b0;
        end else if (clk_en) begin
            tx_reg <= tx_next;
            rx_reg <= rx_next;
        end
    end
    assign serial_transmit_pin = tx_reg;
    assign sci_rx_data         = rx_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_dir_write_drive: assert property (wr_commit && idx == pdp_pkg::IDX_P3_DIR
        |=> p3_dir_reg == ($past(avs_writedata[7:0]) & pdp_pkg::MASK_P3_PINS))
        else $error("port 3 direction write not taken");
    a_alt_owns_pin: assert property (!(|(p3_alt_sel & (p3_oe | p3_out))))
        else $error("alternate pin driven by port");
    a_oe_follows_dir: assert property (wr_commit && idx == pdp_pkg::IDX_P3_DIR
        |=> p3_oe == ($past(avs_writedata[7:0]) & pdp_pkg::MASK_P3_PINS & ~p3_mode_reg))
        else $error("port 3 enable does not follow direction");
    a_dir_read_ones: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P3_DIR |-> avs_readdata[7:1] == 7'h7F)
        else $error("port 3 direction read not ones");
    a_pullup_gate: assert property ($rose(p3_pullup_en[1]) |-> !p3_dir_reg[1])
        else $error("pull-up on an output pin");
    a_p8_read_mix: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P8_DATA |-> avs_readdata[0] ==
        ($past(p8_dir_reg[0]) ? $past(p8_data_reg[0]) : $past(p8_pin)))
        else $error("port 8 data read source wrong");
    a_p8_seg_gate: assert property (p8_oe |-> disp_reg[3:0] == P8_GPIO_SEGMENT)
        else $error("port 8 driven outside its segment code");
    a_p8_dir_one: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P8_DIR |-> avs_readdata == 32'h00000001)
        else $error("port 8 direction read wrong");
    a_mode_two_ones: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P4_MODE_TWO |-> (avs_readdata[7:0] & ~pdp_pkg::MASK_MODE_TWO)
        == pdp_pkg::ONES_MODE_TWO)
        else $error("mode two fixed bits wrong");
    a_tx_invert: assert property (clk_en
        |=> serial_transmit_pin == ($past(sci_tx_data) ^ $past(serial_reg[3])))
        else $error("transmit inversion wrong");
    a_rx_invert: assert property (clk_en
        |=> sci_rx_data == ($past(rx_pin) ^ $past(serial_reg[pdp_pkg::BIT_RX_INV])))
        else $error("receive inversion wrong");
    // Interrupt input must never fight a pin the port still drives
    a_irq_pin_free: assert property (p4_ext_interrupt0_pin_select_sel
        |-> !p4_oe[pdp_pkg::BIT_EXT_INTERRUPT0_PIN_SELECT_PIN] && !p4_out[pdp_pkg::BIT_EXT_INTERRUPT0_PIN_SELECT_PIN])
        else $error("interrupt pin still driven by port");
    a_p3_mode_rsvd: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P3_MODE
        |-> (avs_readdata[7:0] & ~pdp_pkg::MASK_P3_MODE) == 8'h00)
        else $error("port 3 mode reserved bits set");
    a_p9_mode_ones: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_P9_MODE
        |-> (avs_readdata[7:0] & ~pdp_pkg::MASK_P9_MODE) == pdp_pkg::ONES_P9_MODE)
        else $error("port 9 mode fixed bits wrong");
    a_serial_ones: assert property (avs_read && !avs_waitrequest
        && idx == pdp_pkg::IDX_SERIAL_CTRL
        |-> (avs_readdata[7:0] & ~pdp_pkg::MASK_SERIAL) == pdp_pkg::ONES_SERIAL)
        else $error("serial control fixed bits wrong");
    // A master never waits more than one cycle while the clock is enabled
    a_wait_bounded: assert property (req && avs_waitrequest && clk_en
        |=> !avs_waitrequest || !clk_en || !req)
        else $error("wait state longer than one cycle");
    a_freeze_hold: assert property (!clk_en
        |=> $stable(avs_readdata) && $stable(serial_transmit_pin))
        else $error("state moved while clock enable low");
endmodule : pdp_port_regs

// File: logic/pdp_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back.
// Assumes raw levels are asynchronous to sys_clk.
interface pdp_sync_if #(parameter int W = 18);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport syncer (input raw, output clean);
    modport user   (output raw, input clean);
endinterface : pdp_sync_if

// File: tb/pdp_port_regs_bench.sv
// Self-checking bench for the port direction, pull-up and pin-mode registers.
// Assumes the design packages are compiled first; the bench drives every pin itself.
module pdp_port_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [17:0] avs_address = 18'h00000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  p3_in = 8'h0E;
    logic [7:0]  p4_in = 8'h05;
    logic        p8_in = 1'b0;
    logic        serial_receive_pin = 1'b0;
    logic        sci_tx_data = 1'b0;
    logic [7:0]  p3_out, p3_oe, p3_pullup_en, p3_alt_sel, p4_out, p4_oe, p9_out;
    logic [1:0]  p9_pwm_sel;
    logic        p35_pmos_off, p4_ext_interrupt0_pin_select_sel, p8_out, p8_oe, p9_pwm_drive_off;
    logic        serial_transmit_pin, sci_rx_data, serial_pin_function_select;
    int          num_errors = 0;
    int          samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    // Non-zero segment code so a stuck compare against zero is caught
    pdp_port_regs #(.P8_GPIO_SEGMENT(4'h3)) pdp_port_regs_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup_en(p3_pullup_en),
        .p3_alt_sel(p3_alt_sel), .p35_pmos_off(p35_pmos_off),
        .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe), .p4_ext_interrupt0_pin_select_sel(p4_ext_interrupt0_pin_select_sel),
        .p8_in(p8_in), .p8_out(p8_out), .p8_oe(p8_oe),
        .p9_out(p9_out), .p9_pwm_sel(p9_pwm_sel), .p9_pwm_drive_off(p9_pwm_drive_off),
        .serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin),
        .sci_tx_data(sci_tx_data), .sci_rx_data(sci_rx_data),
        .serial_pin_function_select(serial_pin_function_select)
    );
    // ==========================================
    // Report and compare
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED reg at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED pin at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin
    // ==========================================
    // Avalon-MM master: hold the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] rd);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        while (!done) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) begin
                done = 1;
            end else begin
                n++;
                if (n > 50) begin
                    num_errors++;
                    conclude();
                end
            end
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic reg_write(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus(1'b1, idx, d, 4'hF, unused);
    endtask : reg_write
    task automatic reg_check(input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] rd;
        bus(1'b0, idx, 8'h00, 4'hF, rd);
        chk_reg(rd, exp);
    endtask : reg_check
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : settle
    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] unused;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(8);
        // Reset values and fixed read-back
        reg_check(pdp_pkg::IDX_P4_DATA, 8'hFD);
        reg_check(pdp_pkg::IDX_P9_DATA, 8'hFF);
        reg_check(pdp_pkg::IDX_P4_MODE_TWO, 8'hD8);
        reg_check(pdp_pkg::IDX_P9_MODE, 8'hF0);
        reg_check(pdp_pkg::IDX_SERIAL_CTRL, 8'hC0);
        reg_check(pdp_pkg::IDX_P8_DIR, 8'h01);
        // Port 3 direction steers pins though it reads back fixed
        reg_write(pdp_pkg::IDX_P3_DIR, 8'hF0);
        reg_write(pdp_pkg::IDX_P3_DATA, 8'hA0);
        reg_write(pdp_pkg::IDX_P3_PULLUP, 8'hFE);
        settle(8);
        chk_pin(p3_oe, 8'hF0);
        chk_pin(p3_out, 8'hA0);
        chk_pin(p3_pullup_en, 8'h0E);
        reg_check(pdp_pkg::IDX_P3_DIR, 8'hFE);
        reg_check(pdp_pkg::IDX_P3_DATA, 8'hAE);
        reg_check(pdp_pkg::IDX_P3_PULLUP, 8'hFE);
        // Alternate functions take pins away; reserved mode bits dropped
        reg_write(pdp_pkg::IDX_P3_MODE, 8'hFF);
        settle(2);
        reg_check(pdp_pkg::IDX_P3_MODE, 8'hC6);
        chk_pin(p3_alt_sel, 8'hC6);
        chk_pin(p3_oe, 8'h30);
        chk_pin(p3_out, 8'h20);
        // Mode two: interrupt pin select and PMOS off
        reg_write(pdp_pkg::IDX_P4_MODE_TWO, 8'hFF);
        reg_write(pdp_pkg::IDX_P4_DIR, 8'hFF);
        reg_write(pdp_pkg::IDX_P4_DATA, 8'h5A);
        settle(2);
        reg_check(pdp_pkg::IDX_P4_MODE_TWO, 8'hF9);
        chk_pin({6'h00, p35_pmos_off, p4_ext_interrupt0_pin_select_sel}, 8'h03);
        chk_pin(p4_oe, 8'hF7);
        chk_pin(p4_out, 8'h52);
        reg_check(pdp_pkg::IDX_P4_DIR, 8'hFF);
        reg_check(pdp_pkg::IDX_P4_DATA, 8'h5A);
        reg_write(pdp_pkg::IDX_P4_MODE_TWO, 8'h00);
        settle(2);
        chk_pin(p4_oe, 8'hFF);
        chk_pin({6'h00, p35_pmos_off, p4_ext_interrupt0_pin_select_sel}, 8'h00);
        // Single pin port, gated by the segment code
        reg_write(pdp_pkg::IDX_DISPLAY_CTL, 8'h03);
        reg_write(pdp_pkg::IDX_P8_DIR, 8'h01);
        reg_write(pdp_pkg::IDX_P8_DATA, 8'h01);
        settle(8);
        chk_pin({6'h00, p8_oe, p8_out}, 8'h03);
        reg_check(pdp_pkg::IDX_P8_DATA, 8'h01);
        reg_check(pdp_pkg::IDX_P8_DIR, 8'h01);
        reg_write(pdp_pkg::IDX_P8_DIR, 8'h00);
        settle(8);
        reg_check(pdp_pkg::IDX_P8_DATA, 8'h00);
        reg_write(pdp_pkg::IDX_P8_DIR, 8'h01);
        reg_write(pdp_pkg::IDX_DISPLAY_CTL, 8'h00);
        settle(2);
        chk_pin({7'h00, p8_oe}, 8'h00);
        // Third port mode and data
        reg_write(pdp_pkg::IDX_P9_MODE, 8'hFF);
        reg_write(pdp_pkg::IDX_P9_DATA, 8'h3C);
        settle(2);
        reg_check(pdp_pkg::IDX_P9_MODE, 8'hFB);
        chk_pin({5'h00, p9_pwm_drive_off, p9_pwm_sel}, 8'h07);
        chk_pin(p9_out, 8'h3C);
        // Serial inversion in both directions
        sci_tx_data <= 1'b1;
        serial_receive_pin <= 1'b1;
        settle(8);
        chk_pin({6'h00, serial_transmit_pin, sci_rx_data}, 8'h03);
        reg_write(pdp_pkg::IDX_SERIAL_CTRL, 8'hFF);
        settle(8);
        reg_check(pdp_pkg::IDX_SERIAL_CTRL, 8'hEC);
        chk_pin({6'h00, serial_transmit_pin, sci_rx_data}, 8'h00);
        chk_pin({7'h00, serial_pin_function_select}, 8'h01);
        sci_tx_data <= 1'b0;
        serial_receive_pin <= 1'b0;
        settle(8);
        chk_pin({6'h00, serial_transmit_pin, sci_rx_data}, 8'h03);
        // Clock enable low freezes the transmit path
        @(posedge sys_clk);
        clk_en <= 1'b0;
        sci_tx_data <= 1'b1;
        settle(4);
        chk_pin({7'h00, serial_transmit_pin}, 8'h01);
        clk_en <= 1'b1;
        settle(2);
        chk_pin({7'h00, serial_transmit_pin}, 8'h00);
        sci_tx_data <= 1'b0;
        // Refused accesses: unmapped index, lane zero disabled
        reg_check(16'h0123, 8'h00);
        bus(1'b1, pdp_pkg::IDX_P9_DATA, 8'h00, 4'hE, unused);
        reg_check(pdp_pkg::IDX_P9_DATA, 8'h3C);
        // Second reset restores defaults
        @(posedge sys_clk);
        rst_n <= 1'b0;
        settle(6);
        rst_n <= 1'b1;
        settle(2);
        reg_check(pdp_pkg::IDX_P9_DATA, 8'hFF);
        chk_pin(p4_oe, 8'hF8);
        conclude();
    end
endmodule : pdp_port_regs_bench
